// [shared/gpt_pkg.sv]
package gpt_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_AMODE = 8'h04;
  localparam logic [7:0] OFS_BMODE = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_IMASK = 8'h18;
  localparam logic [7:0] OFS_RIS = 8'h1C;
  localparam logic [7:0] OFS_MIS = 8'h20;
  localparam logic [7:0] OFS_ICLR = 8'h24;
  localparam logic [7:0] OFS_ALOAD = 8'h28;
  localparam logic [7:0] OFS_BLOAD = 8'h2C;
  localparam logic [7:0] OFS_AMATCH = 8'h30;
  localparam logic [7:0] OFS_APS = 8'h38;
  localparam logic [7:0] OFS_BPS = 8'h3C;
  localparam logic [7:0] OFS_ACNT = 8'h48;
  localparam logic [7:0] OFS_BCNT = 8'h4C;
  // configuration and mode codes
  localparam logic [2:0] CFG_32_TIMER = 3'h0;
  localparam logic [2:0] CFG_RTC = 3'h1;
  localparam logic [2:0] CFG_16_PAIR = 3'h4;
  localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  // reset values and calendar first load
  localparam logic [15:0] RST_COUNT = 16'hFFFF;
  localparam logic [15:0] RST_LOAD = 16'hFFFF;
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic [31:0] RTC_FIRST_LOAD = 32'h00000001;
  // control bit positions, channel b sits CTL_B_SHIFT higher
  localparam int CTL_EN = 0;
  localparam int CTL_STALL = 1;
  localparam int CTL_CAL = 4;
  localparam int CTL_OTE = 5;
  localparam int CTL_B_SHIFT = 8;
  // status bit positions
  localparam int ST_A_TIMEOUT = 0;
  localparam int ST_RTC = 3;
  localparam int ST_B_TIMEOUT = 8;
  // calendar input rate, rising edges per second
  localparam int RTC_IN_HZ = 32768;

  typedef struct packed {
    logic ote;
    logic stall_en;
    logic en;
  } gpt_chan_ctrl_s;
endpackage : gpt_pkg

// [verilog/gpt_timer_unit.sv]
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ns
module gpt_timer_unit #(
  parameter int RTC_DIV = gpt_pkg::RTC_IN_HZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic stall_i,
  input wire logic capture_pin_even_zero_i,
  output logic [1:0] trigger_o,
  output logic irq_o
);
  import gpt_pkg::*;

  localparam int DIV_W = $clog2(RTC_DIV);

  logic [2:0] cfg;
  logic [1:0] mode [2];
  gpt_chan_ctrl_s ctl [2];
  logic cal_en;
  logic [15:0] load [2];
  logic [15:0] cnt [2];
  logic [7:0] ps_load [2];
  logic [7:0] psc [2];
  logic [31:0] match;
  logic [8:0] imask;
  logic [8:0] raw;
  logic [1:0] rel_pend;
  logic [1:0] zero_rl;
  logic [1:0] hit;
  logic [1:0] hit16;
  logic [1:0] run16;
  logic rtc_seen;
  logic rtc_tick;
  logic pin_q;
  logic [DIV_W-1:0] div;
  logic [31:0] next_cnt32;
  logic hit32;
  logic rtc_hit;

  wire is_rtc = (cfg == CFG_RTC);
  wire is16 = (cfg == CFG_16_PAIR);
  wire is32 = ~is_rtc & ~is16;
  wire [31:0] cnt32 = {cnt[1], cnt[0]};
  wire [31:0] load32 = {load[1], load[0]};
  wire rtc_first = is_rtc & ~rtc_seen;
  wire run32 = ctl[0].en & ~(ctl[0].stall_en & stall_i);
  wire rtc_stall = (ctl[0].stall_en | ctl[1].stall_en) & stall_i & ~cal_en;
  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire wr = bus_req & we_i;
  wire [31:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [31:0] clr_bits = (wr && adr_i == OFS_ICLR) ? (dat_i & wmask) : 32'h00000000;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [31:0] m);
    merge = (old & ~m) | (val & m);
  endfunction : merge

  // bus answer, registered, one wait cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= CFG_32_TIMER;
      match <= 32'hFFFFFFFF;
      imask <= 9'h000;
    end else if (wr) begin
      if (adr_i == OFS_CFG) begin
        cfg <= 3'(merge({29'h0, cfg}, dat_i, wmask));
      end
      if (adr_i == OFS_AMATCH) begin
        match <= merge(match, dat_i, wmask);
      end
      if (adr_i == OFS_IMASK) begin
        imask <= 9'(merge({23'h0, imask}, dat_i, wmask));
      end
    end
  end

  // control, enables cleared by one-shot timeout after any write
  always_ff @(posedge clk_i) begin
    logic [31:0] c;
    c = 32'h00000000;
    if (rst_i) begin
      ctl[0] <= '0;
      ctl[1] <= '0;
      cal_en <= 1'b0;
    end else begin
      c = {18'h0, ctl[1].ote, 3'h0, ctl[1].stall_en, ctl[1].en, 2'h0, ctl[0].ote, cal_en, 2'h0,
           ctl[0].stall_en, ctl[0].en};
      if (wr && adr_i == OFS_CTRL) begin
        c = merge(c, dat_i, wmask);
      end
      for (int i = 0; i < 2; i++) begin
        ctl[i].en <= c[CTL_EN + CTL_B_SHIFT * i] &
                     ~(hit[i] & (is16 ? mode[i] : mode[0]) == MODE_ONE_SHOT & ~is_rtc);
        ctl[i].stall_en <= c[CTL_STALL + CTL_B_SHIFT * i];
        ctl[i].ote <= c[CTL_OTE + CTL_B_SHIFT * i];
      end
      cal_en <= c[CTL_CAL];
    end
  end

  // calendar input divider, one tick per second of pin edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= 1'b0;
      div <= '0;
      rtc_tick <= 1'b0;
      rtc_seen <= 1'b0;
    end else begin
      pin_q <= capture_pin_even_zero_i;
      rtc_tick <= 1'b0;
      if (rtc_first) begin
        rtc_seen <= 1'b1;
      end
      if (!(is_rtc && ctl[0].en)) begin
        div <= '0;
      end else if (capture_pin_even_zero_i & ~pin_q) begin
        if (div == DIV_W'(RTC_DIV - 1)) begin
          div <= '0;
          rtc_tick <= 1'b1;
        end else begin
          div <= div + 1'b1;
        end
      end
    end
  end

  // joined counter next value
  always_comb begin
    next_cnt32 = cnt32;
    hit32 = 1'b0;
    rtc_hit = 1'b0;
    if (is_rtc) begin
      if (rtc_first) begin
        next_cnt32 = RTC_FIRST_LOAD;
      end else if (ctl[0].en & rtc_tick & ~rtc_stall) begin
        if (cnt32 == match) begin
          next_cnt32 = 32'h00000000;
          rtc_hit = 1'b1;
        end else begin
          next_cnt32 = cnt32 + 32'h00000001;
        end
      end
    end else if (rel_pend[0] | zero_rl[0]) begin
      next_cnt32 = load32;
    end else if (run32 && cnt32 != 32'h00000000) begin
      next_cnt32 = cnt32 - 32'h00000001;
      hit32 = (cnt32 == 32'h00000001);
    end
  end

  // per-counter storage and separate-mode counting
  for (genvar i = 0; i < 2; i++) begin : g_chan
    assign run16[i] = ctl[i].en & ~(ctl[i].stall_en & stall_i);
    assign hit16[i] = run16[i] & ~rel_pend[i] & (psc[i] == 8'h00) & (cnt[i] == 16'h0001);
    assign hit[i] = is16 ? hit16[i] : (i == 0) & hit32;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mode[i] <= 2'h0;
        load[i] <= RST_LOAD;
        ps_load[i] <= RST_PRESCALE;
        rel_pend[i] <= 1'b0;
      end else begin
        rel_pend[i] <= 1'b0;
        if (wr && adr_i == (i == 0 ? OFS_AMODE : OFS_BMODE)) begin
          mode[i] <= 2'(merge({30'h0, mode[i]}, dat_i, wmask));
        end
        if (wr && adr_i == (i == 0 ? OFS_APS : OFS_BPS)) begin
          ps_load[i] <= 8'(merge({24'h0, ps_load[i]}, dat_i, wmask));
        end
        if (wr && adr_i == OFS_ALOAD && !is16) begin
          load[i] <= 16'(merge(load32, dat_i, wmask) >> (16 * i));
          rel_pend[i] <= 1'b1;
        end else if (wr && adr_i == (i == 0 ? OFS_ALOAD : OFS_BLOAD)) begin
          load[i] <= 16'(merge({16'h0, load[i]}, dat_i, wmask));
          rel_pend[i] <= 1'b1;
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt[i] <= RST_COUNT;
        psc[i] <= RST_PRESCALE;
        zero_rl[i] <= 1'b0;
      end else begin
        zero_rl[i] <= hit[i];
        if (!is16) begin
          cnt[i] <= next_cnt32[16 * i +: 16];
        end else if (rel_pend[i] | zero_rl[i]) begin
          cnt[i] <= load[i];
          psc[i] <= ps_load[i];
        end else if (run16[i] && (cnt[i] != 16'h0000)) begin
          if (psc[i] != 8'h00) begin
            psc[i] <= psc[i] - 8'h01;
          end else begin
            psc[i] <= ps_load[i];
            cnt[i] <= cnt[i] - 16'h0001;
          end
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        trigger_o[i] <= 1'b0;
      end else begin
        trigger_o[i] <= hit[i] & ctl[i].ote;
      end
    end
  end

  // sticky status, a new event wins over a clear
  always_ff @(posedge clk_i) begin
    logic [8:0] s;
    s = 9'h000;
    if (rst_i) begin
      raw <= 9'h000;
      irq_o <= 1'b0;
    end else begin
      s[ST_A_TIMEOUT] = hit[0];
      s[ST_B_TIMEOUT] = hit[1] & is16;
      s[ST_RTC] = rtc_hit;
      raw <= (raw & ~clr_bits[8:0]) | s;
      irq_o <= |(raw & imask);
    end
  end

  // read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (bus_req && !we_i) begin
      case (adr_i)
        OFS_CFG: dat_o <= {29'h0, cfg};
        OFS_AMODE: dat_o <= {30'h0, mode[0]};
        OFS_BMODE: dat_o <= {30'h0, mode[1]};
        OFS_CTRL: dat_o <= {18'h0, ctl[1].ote, 3'h0, ctl[1].stall_en, ctl[1].en, 2'h0, ctl[0].ote, cal_en,
                            2'h0, ctl[0].stall_en, ctl[0].en};
        OFS_IMASK: dat_o <= {23'h0, imask};
        OFS_RIS: dat_o <= {23'h0, raw};
        OFS_MIS: dat_o <= {23'h0, raw & imask};
        OFS_ALOAD: dat_o <= is16 ? {16'h0, load[0]} : load32;
        OFS_BLOAD: dat_o <= {16'h0, load[1]};
        OFS_AMATCH: dat_o <= match;
        OFS_APS: dat_o <= {24'h0, ps_load[0]};
        OFS_BPS: dat_o <= {24'h0, ps_load[1]};
        OFS_ACNT: dat_o <= is16 ? {16'h0, cnt[0]} : cnt32;
        OFS_BCNT: dat_o <= {16'h0, cnt[1]};
        default: dat_o <= 32'h00000000;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_reset_values: assert property ($past(rst_i) |-> cnt32 == {RST_COUNT, RST_COUNT}
    && load32 == {RST_LOAD, RST_LOAD} && psc[0] == RST_PRESCALE && ps_load[1] == RST_PRESCALE)
    else $error("reset values wrong");
  chk_reset_idle: assert property ($past(rst_i) |-> !ctl[0].en && !ctl[1].en && cfg == CFG_32_TIMER)
    else $error("unit not idle after reset");
  chk_oneshot_stop: assert property (is32 && hit32 && mode[0] == MODE_ONE_SHOT |=> !ctl[0].en
    ##1 cnt32 == $past(load32, 2))
    else $error("one-shot did not stop and reload");
  chk_periodic_run: assert property (is32 && hit32 && mode[0] == MODE_PERIODIC && !wr |=> ctl[0].en)
    else $error("periodic enable lost");
  chk_trigger_pulse: assert property (hit[0] && ctl[0].ote |=> trigger_o[0] && cnt[0] == 16'h0000
    ##1 !trigger_o[0])
    else $error("trigger not one clock");
  chk_timeout_flag: assert property (hit[0] |=> raw[ST_A_TIMEOUT] ##1 raw[ST_A_TIMEOUT] || $past(clr_bits[0]))
    else $error("timeout flag not held");
  chk_masked_irq: assert property (hit[0] && imask[ST_A_TIMEOUT] |=> ##1 irq_o)
    else $error("masked timeout missing");
  chk_load_take: assert property (is32 && rel_pend[0] |=> cnt32 == $past(load32))
    else $error("load not taken next clock");
  chk_stall_hold: assert property (is32 && ctl[0].stall_en && stall_i && !rel_pend[0] && !zero_rl[0]
    |=> $stable(cnt32))
    else $error("counter moved while stalled");
  chk_rtc_first: assert property (rtc_first |=> cnt32 == RTC_FIRST_LOAD)
    else $error("calendar first load wrong");
  chk_rtc_roll: assert property (rtc_hit |=> cnt32 == 32'h00000000 && raw[ST_RTC])
    else $error("calendar match did not roll over");
  chk_prescale_step: assert property (is16 && run16[1] && psc[1] != 8'h00 && cnt[1] != 16'h0000
    && !rel_pend[1] && !zero_rl[1] |=> psc[1] == $past(psc[1]) - 8'h01 && $stable(cnt[1]))
    else $error("prescaler step wrong");
  chk_load_split: assert property (!is16 && wr && adr_i == OFS_ALOAD && sel_i == 4'hF
    |=> load32 == $past(dat_i))
    else $error("joined load write not split");
  chk_joined_read: assert property (!is16 && bus_req && !we_i && adr_i == OFS_ACNT
    |=> dat_o == $past(cnt32))
    else $error("joined count read wrong");
  chk_cfg_write: assert property (wr && adr_i == OFS_CFG && sel_i[0] |=> cfg == $past(dat_i[2:0]))
    else $error("configuration not taken");
  chk_b_quiet_joined: assert property (!is16 && !raw[ST_B_TIMEOUT] |=> !raw[ST_B_TIMEOUT])
    else $error("counter b flagged in joined mode");
  chk_joined_down: assert property (is32 && run32 && cnt32 != 32'h00000000 && !rel_pend[0] && !zero_rl[0]
    |=> cnt32 == $past(cnt32) - 32'h00000001)
    else $error("joined counter did not count down");
  chk_joined_reload: assert property (is32 && zero_rl[0] |=> cnt32 == $past(load32))
    else $error("joined counter did not reload");
  chk_sep_oneshot: assert property (is16 && hit16[1] && mode[1] == MODE_ONE_SHOT |=> !ctl[1].en)
    else $error("separate one-shot kept running");
  chk_sep_periodic: assert property (is16 && hit16[0] && mode[0] == MODE_PERIODIC && !wr |=> ctl[0].en)
    else $error("separate periodic enable lost");
  chk_b_timeout_flag: assert property (is16 && hit[1] |=> raw[ST_B_TIMEOUT])
    else $error("counter b timeout flag missing");
  chk_flag_clear: assert property (wr && adr_i == OFS_ICLR && sel_i[0] && dat_i[0] && !hit[0]
    |=> !raw[ST_A_TIMEOUT])
    else $error("timeout flag not cleared");
  chk_masked_read: assert property (bus_req && !we_i && adr_i == OFS_MIS
    |=> dat_o == {23'h0, $past(raw & imask)})
    else $error("masked status read wrong");
  chk_trigger_a_idle: assert property (!(hit[0] && ctl[0].ote) |=> !trigger_o[0])
    else $error("spurious trigger a");
  chk_trigger_b_idle: assert property (!(hit[1] && ctl[1].ote) |=> !trigger_o[1])
    else $error("spurious trigger b");
  chk_rtc_hold: assert property (is_rtc && !rtc_first && !rtc_tick |=> $stable(cnt32))
    else $error("calendar moved without tick");
  chk_rtc_count_up: assert property (is_rtc && !rtc_first && ctl[0].en && rtc_tick && !rtc_stall
    && cnt32 != match |=> cnt32 == $past(cnt32) + 32'h00000001)
    else $error("calendar did not count up");
  chk_rtc_match_irq: assert property (rtc_hit && imask[ST_RTC] |=> ##1 irq_o)
    else $error("calendar interrupt missing");
  chk_rtc_no_stall: assert property (is_rtc && !rtc_first && cal_en && ctl[0].en && rtc_tick && stall_i
    && cnt32 != 32'h00000000 |=> cnt32 != $past(cnt32))
    else $error("calendar stalled");
  chk_sep_reload: assert property (is16 && (rel_pend[0] || zero_rl[0])
    |=> cnt[0] == $past(load[0]) && psc[0] == $past(ps_load[0]))
    else $error("separate reload wrong");

  cov_oneshot: cover property (is32 && hit32 && mode[0] == MODE_ONE_SHOT);
  cov_rtc_match: cover property (rtc_hit);
  cov_sep_timeout: cover property (is16 && hit[1] ##1 trigger_o[1]);
  cov_stall_hold: cover property (is32 && ctl[0].en && ctl[0].stall_en && stall_i);
  cov_load_running: cover property (is32 && ctl[0].en && rel_pend[0]);
endmodule : gpt_timer_unit

// [sim/tb_gpt_timer_unit.sv]
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb_gpt_timer_unit;
  import gpt_pkg::*;
  localparam int DIV = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic stall_i = 1'b0;
  logic capture_pin_even_zero_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o;
  logic ack_o;
  logic [1:0] trigger_o;
  logic irq_o;
  int errors = 0;
  int total_checks = 0;
  int seed = 3;
  logic rtc_run = 1'b0;
  string names[$];
  logic [31:0] exps[$];

  always #4 clk_i = ~clk_i;

  gpt_timer_unit #(.RTC_DIV(DIV)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .stall_i(stall_i), .capture_pin_even_zero_i(capture_pin_even_zero_i), .trigger_o(trigger_o),
    .irq_o(irq_o));

  // calendar input, still unless running
  always begin : cal_src
    @(posedge clk_i);
    if (rtc_run) begin
      repeat (2) @(posedge clk_i);
      capture_pin_even_zero_i <= ~capture_pin_even_zero_i;
    end
  end

  // read results against oldest note
  always @(posedge clk_i) begin : monitor
    string nm;
    logic [31:0] ex;
    if (ack_o === 1'b1 && cyc_i === 1'b1 && we_i === 1'b0 && exps.size() > 0) begin
      nm = names.pop_front();
      ex = exps.pop_front();
      `CHK(nm, ex, dat_o)
    end
  end

  task automatic results;
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    if (i == 50) begin
      errors++;
      results();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    names.push_back(nm);
    exps.push_back(ex);
    bus(1'b0, a, 32'h00000000);
  endtask : rd

  task automatic wait_trig(input int idx, output int n);
    for (n = 0; n < 3000; n++) begin
      @(posedge clk_i);
      if (trigger_o[idx] === 1'b1) return;
    end
    errors++;
    results();
  endtask : wait_trig

  initial begin : main
    int n;
    int nv;
    int p;
    logic [31:0] lv;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("trigger idle", 2'b00, trigger_o)
    `CHK("irq idle", 1'b0, irq_o)
    rd(OFS_ACNT, 32'hFFFFFFFF, "count a reset");
    rd(OFS_BCNT, 32'h0000FFFF, "count b reset");
    rd(OFS_BLOAD, 32'h0000FFFF, "load b reset");
    rd(OFS_APS, 32'h00000000, "prescale a reset");
    rd(OFS_BPS, 32'h00000000, "prescale b reset");
    rd(OFS_CTRL, 32'h00000000, "control reset");
    rd(OFS_CFG, 32'h00000000, "config reset");
    rd(OFS_RIS, 32'h00000000, "raw reset");
    rd(8'h7C, 32'h00000000, "unmapped");
    lv = $random(seed);
    wr(OFS_ALOAD, lv);
    rd(OFS_BLOAD, {16'h0000, lv[31:16]}, "load b upper");
    rd(OFS_ACNT, lv, "joined count");
    nv = 8 + ($random(seed) & 15);
    wr(OFS_AMODE, {30'h0, MODE_ONE_SHOT});
    wr(OFS_IMASK, 32'h00000109);
    wr(OFS_ALOAD, nv);
    wr(OFS_CTRL, 32'h00000021);
    wait_trig(0, n);
    `CHK("one shot time", 1'b1, n >= nv - 3 && n <= nv + 1)
    @(posedge clk_i);
    `CHK("trigger width", 1'b0, trigger_o[0])
    rd(OFS_CTRL, 32'h00000020, "one shot stop");
    rd(OFS_ACNT, nv, "reload");
    rd(OFS_RIS, 32'h00000001, "raw timeout");
    rd(OFS_MIS, 32'h00000001, "masked timeout");
    `CHK("irq timeout", 1'b1, irq_o)
    wr(OFS_ICLR, 32'h00000001);
    rd(OFS_RIS, 32'h00000000, "raw cleared");
    wr(OFS_BMODE, {30'h0, MODE_ONE_SHOT});
    wr(OFS_AMODE, {30'h0, MODE_PERIODIC});
    wr(OFS_CTRL, 32'h00000021);
    wait_trig(0, n);
    wait_trig(0, n);
    `CHK("period", nv, n)
    nv = 8 + ($random(seed) & 15);
    wr(OFS_ALOAD, nv);
    wait_trig(0, n);
    wait_trig(0, n);
    `CHK("new load period", nv, n)
    wr(OFS_CTRL, 32'h00000023);
    wait_trig(0, n);
    stall_i <= 1'b1;
    p = 0;
    repeat (60) begin
      @(posedge clk_i);
      if (trigger_o[0] === 1'b1) p++;
    end
    `CHK("stalled", 0, p)
    stall_i <= 1'b0;
    wait_trig(0, n);
    `CHK("resumed", 1'b1, n <= nv + 1)
    wr(OFS_CTRL, 32'h00000000);
    wr(OFS_ICLR, 32'h00000109);
    wr(OFS_CFG, {29'h0, CFG_16_PAIR});
    p = 1 + ($random(seed) & 3);
    wr(OFS_BPS, p);
    wr(OFS_BLOAD, nv);
    wr(OFS_ALOAD, 32'h00000003);
    wr(OFS_CTRL, 32'h00002121);
    wait_trig(1, n);
    `CHK("prescaled time", 1'b1, n >= nv * (p + 1) - 4 && n <= (nv + 1) * (p + 1) + 2)
    rd(OFS_CTRL, 32'h00002021, "b stops a runs");
    rd(OFS_RIS, 32'h00000101, "both timeouts");
    rd(OFS_BPS, p, "prescale kept");
    wr(OFS_CTRL, 32'h00000000);
    wr(OFS_ICLR, 32'h00000109);
    wr(OFS_CFG, {29'h0, CFG_RTC});
    rd(OFS_ACNT, RTC_FIRST_LOAD, "calendar first");
    wr(OFS_AMATCH, 32'h00000002);
    stall_i <= 1'b1;
    wr(OFS_CTRL, 32'h00000013);
    rtc_run <= 1'b1;
    for (n = 0; n < 400 && irq_o !== 1'b1; n++) @(posedge clk_i);
    `CHK("calendar match", 1'b1, n < 400)
    if (n >= 400) results();
    rd(OFS_ACNT, 32'h00000000, "rolled over");
    rd(OFS_RIS, 32'h00000008, "raw match");
    rd(OFS_MIS, 32'h00000008, "masked match");
    wr(OFS_ICLR, 32'h00000008);
    rd(OFS_RIS, 32'h00000000, "match cleared");
    `CHK("irq cleared", 1'b0, irq_o)
    rtc_run <= 1'b0;
    stall_i <= 1'b0;
    results();
  end
endmodule : tb_gpt_timer_unit
